// ### src/transceiver_status_flags.sv
// read-only status register of the contactless transceiver unit
//
// Overview of operation
// - bit 7 high when any enabled group-one interrupt source is pending.
// - bit 4 high when any enabled group-zero interrupt source is pending.
// - bit 6 low during CRC calculation, high when done with zero remainder.
// - bit 6 undefined during frames; receive CRC failure uses separate error flag.
// - bit 5 set when a compute-CRC command calculation finishes; only then meaningful.
// - bit 3 high while the unit timer runs and will decrement next tick.
// - in gated mode bit 3 follows enable bits only, not the gate level.
// - bit 2 shows the live field detector output, never latched.
// - bit 1 high when 64 minus fill count is at most the threshold.
// - bit 0 high when fill count is at most the threshold.
// - fill count comes from the single 64-byte byte-wide staging FIFO.
`timescale 1ns/1ns
`include "xcvr_status_params.svh"

module transceiver_status_flags
    import xcvr_status_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int IRQ_SRC_W = `IRQ_SRC_W
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DATA_W-1:0] reg_rdata,
    // interrupt sources and their enables
    input wire logic [IRQ_SRC_W-1:0] irq_one_src,
    input wire logic [IRQ_SRC_W-1:0] irq_one_en,
    input wire logic [IRQ_SRC_W-1:0] irq_zero_src,
    input wire logic [IRQ_SRC_W-1:0] irq_zero_en,
    // crc coprocessor
    input wire crc_events_t crc_ev,
    // unit timer
    input wire logic timer_enabled,
    input wire logic timer_gated_mode,
    input wire logic timer_gate,
    // field detector pin
    input wire logic field_detect_pin,
    // fifo level and water mark
    input wire logic [6:0] fifo_fill_count,
    input wire logic [5:0] fifo_threshold,
    // live status for other blocks
    output status_flags_t status
);

    generate
        if (FIFO_DEPTH != 64 || IRQ_SRC_W < 1)
        begin : g_bad_param
            $error("unsupported fifo depth or interrupt width");
        end
    endgenerate

    // field detector crossing
    logic field_meta;
    logic field_sync;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            field_meta <= 1'b0;
            field_sync <= 1'b0;
        end
        else
        begin
            field_meta <= field_detect_pin;
            field_sync <= field_meta;
        end
    end

    // crc tracking
    crc_state_t crc_state;
    crc_state_t next_crc_state;
    logic crc_zero;
    logic next_crc_zero;
    logic crc_done_flag;
    logic next_crc_done_flag;

    always_comb
    begin
        next_crc_state = crc_state;
        next_crc_zero = crc_zero;
        next_crc_done_flag = crc_done_flag;
        case (crc_state)
            CRC_IDLE:
            begin
                if (crc_ev.start)
                begin
                    next_crc_zero = 1'b0;
                    if (crc_ev.from_command)
                    begin
                        next_crc_state = CRC_CMD_RUN;
                        next_crc_done_flag = 1'b0;
                    end
                    else
                    begin
                        // frame crc: result bit carries no meaning here
                        next_crc_state = CRC_FRAME_RUN;
                    end
                end
            end
            CRC_CMD_RUN:
            begin
                if (crc_ev.busy)
                begin
                    next_crc_zero = 1'b0;
                end
                if (crc_ev.finish)
                begin
                    next_crc_zero = crc_ev.remainder_zero;
                    next_crc_done_flag = 1'b1;
                    next_crc_state = CRC_IDLE;
                end
            end
            CRC_FRAME_RUN:
            begin
                if (crc_ev.busy)
                begin
                    next_crc_zero = 1'b0;
                end
                if (crc_ev.finish)
                begin
                    // receive failures go to the error flag elsewhere
                    next_crc_zero = crc_ev.remainder_zero;
                    next_crc_state = CRC_IDLE;
                end
            end
            default:
            begin
                next_crc_state = CRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            crc_state <= CRC_IDLE;
            crc_zero <= 1'b0;
            crc_done_flag <= 1'b1;
        end
        else
        begin
            crc_state <= next_crc_state;
            crc_zero <= next_crc_zero;
            crc_done_flag <= next_crc_done_flag;
        end
    end

    // status flag assembly
    status_flags_t next_status;
    logic [7:0] free_space;

    always_comb
    begin
        // widen before subtracting so 64 never wraps
        free_space = 8'(FIFO_DEPTH) - {1'b0, fifo_fill_count};
        next_status.irq_group_one_pending = |(irq_one_src & irq_one_en);
        next_status.irq_group_zero_pending = |(irq_zero_src & irq_zero_en);
        next_status.crc_result_zero = next_crc_zero;
        next_status.crc_done = next_crc_done_flag;
        // gate level deliberately unused: flag follows enables only
        next_status.timer_active = timer_enabled;
        next_status.field_present = field_sync;
        next_status.fifo_nearly_full = free_space <= {2'b00, fifo_threshold};
        next_status.fifo_nearly_empty = fifo_fill_count <= {1'b0, fifo_threshold};
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            status <= status_flags_t'(`STATUS_RESET);
        end
        else
        begin
            status <= next_status;
        end
    end

    // register read port; writes never reach any state
    logic [`DATA_W-1:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_rd && reg_addr == `STATUS_OFFSET)
        begin
            next_rdata = status;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_irq_one_gated: assert property (
        ##1 status.irq_group_one_pending == |($past(irq_one_src) & $past(irq_one_en)))
        else $error("group one flag does not match enabled sources");
    chk_irq_zero_gated: assert property (
        ##1 status.irq_group_zero_pending == |($past(irq_zero_src) & $past(irq_zero_en)))
        else $error("group zero flag does not match enabled sources");
    chk_crc_busy_low: assert property (
        crc_ev.busy && !crc_ev.finish && crc_state != CRC_IDLE |=> !status.crc_result_zero)
        else $error("crc zero flag high during calculation");
    chk_crc_zero_end: assert property (
        crc_ev.finish && crc_state != CRC_IDLE |=> status.crc_result_zero == $past(crc_ev.remainder_zero))
        else $error("crc zero flag wrong after finish");
    chk_crc_done_cmd: assert property (
        crc_ev.finish && crc_state == CRC_CMD_RUN |=> status.crc_done)
        else $error("crc done not set after command");
    chk_crc_done_frame: assert property (
        crc_state == CRC_FRAME_RUN |=> status.crc_done == $past(status.crc_done))
        else $error("crc done changed by frame crc");
    chk_timer_follows: assert property (
        timer_enabled && timer_gated_mode && !timer_gate |=> status.timer_active)
        else $error("timer flag follows gate level");
    // two sync stages plus the status register: the pin shows three edges later
    chk_field_live: assert property (
        !field_detect_pin [*3] |=> !status.field_present)
        else $error("field flag latched after field loss");
    chk_nearly_full: assert property (
        ##1 status.fifo_nearly_full == ((7'd64 - $past(fifo_fill_count)) <= {1'b0, $past(fifo_threshold)}))
        else $error("nearly full flag wrong");
    chk_nearly_empty: assert property (
        ##1 status.fifo_nearly_empty == ($past(fifo_fill_count) <= {1'b0, $past(fifo_threshold)}))
        else $error("nearly empty flag wrong");
    chk_read_data: assert property (
        reg_rd && reg_addr == `STATUS_OFFSET |=> reg_rdata == $past(status))
        else $error("read data does not show status");
    chk_write_ignored: assert property (
        reg_wr && !reg_rd |=> reg_rdata == 8'h00)
        else $error("write produced read data");

    cov_cmd_crc: cover property (crc_ev.finish && crc_state == CRC_CMD_RUN && crc_ev.remainder_zero);
    cov_full_alert: cover property (status.fifo_nearly_full && reg_rd);
    cov_field_drop: cover property (status.field_present ##1 !status.field_present);
    cov_gated_timer: cover property (timer_gated_mode && !timer_gate && status.timer_active);

endmodule : transceiver_status_flags

// ### include/xcvr_status_params.svh
// offsets, bit positions, reset values and sizes of the transceiver status register
`ifndef XCVR_STATUS_PARAMS_SVH
`define XCVR_STATUS_PARAMS_SVH

`define STATUS_OFFSET 8'hDF
`define ADDR_W 8
`define DATA_W 8

`define BIT_IRQ_ONE 7
`define BIT_CRC_ZERO 6
`define BIT_CRC_DONE 5
`define BIT_IRQ_ZERO 4
`define BIT_TIMER 3
`define BIT_FIELD 2
`define BIT_NEAR_FULL 1
`define BIT_NEAR_EMPTY 0

`define STATUS_RESET 8'h21
`define FIFO_DEPTH 64
`define IRQ_SRC_W 8

`endif

// ### include/xcvr_status_pkg.sv
// types shared by the transceiver status register block
package xcvr_status_pkg;

    typedef struct packed {
        logic irq_group_one_pending;
        logic crc_result_zero;
        logic crc_done;
        logic irq_group_zero_pending;
        logic timer_active;
        logic field_present;
        logic fifo_nearly_full;
        logic fifo_nearly_empty;
    } status_flags_t;

    typedef struct packed {
        logic start;
        logic from_command;
        logic busy;
        logic finish;
        logic remainder_zero;
    } crc_events_t;

    typedef enum logic [1:0] {
        CRC_IDLE,
        CRC_CMD_RUN,
        CRC_FRAME_RUN
    } crc_state_t;

endpackage : xcvr_status_pkg

// ### bench/tb_transceiver_status_flags.sv
// self-checking bench for the transceiver status register
`timescale 1ns/1ns
`include "xcvr_status_params.svh"

module tb_transceiver_status_flags
    import xcvr_status_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] irq_one_src = 8'h00;
    logic [7:0] irq_one_en = 8'h00;
    logic [7:0] irq_zero_src = 8'h00;
    logic [7:0] irq_zero_en = 8'h00;
    crc_events_t crc_ev = '0;
    logic timer_enabled = 1'b0;
    logic timer_gated_mode = 1'b0;
    logic timer_gate = 1'b0;
    logic field_detect_pin = 1'b0;
    logic [6:0] fifo_fill_count = 7'h00;
    logic [5:0] fifo_threshold = 6'h00;
    status_flags_t status;
    int n_mismatch = 0;
    int checked = 0;

    transceiver_status_flags transceiver_status_flags_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_one_src(irq_one_src), .irq_one_en(irq_one_en), .irq_zero_src(irq_zero_src),
        .irq_zero_en(irq_zero_en), .crc_ev(crc_ev), .timer_enabled(timer_enabled),
        .timer_gated_mode(timer_gated_mode), .timer_gate(timer_gate), .field_detect_pin(field_detect_pin),
        .fifo_fill_count(fifo_fill_count), .fifo_threshold(fifo_threshold), .status(status));

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // let the input edge pass, then the flag edge, then settle
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic t_regs();
        chk(status, 8'h21);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'hDF;
        reg_wdata <= 8'hDE;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        rd(8'hDF, 8'h21);
        rd(8'hDE, 8'h00);
        rd(8'hDF, 8'h21);
    endtask : t_regs

    task automatic t_irq();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge sys_clk);
            irq_one_src <= 8'h01 << i;
            irq_zero_src <= 8'h01 << i;
            irq_one_en <= ~(8'h01 << i);
            irq_zero_en <= 8'h01 << i;
            settle(2);
            chk({7'h00, status.irq_group_one_pending}, 8'h00);
            chk({7'h00, status.irq_group_zero_pending}, 8'h01);
            @(posedge sys_clk);
            irq_one_en <= 8'h01 << i;
            irq_zero_en <= ~(8'h01 << i);
            settle(2);
            chk({7'h00, status.irq_group_one_pending}, 8'h01);
            chk({7'h00, status.irq_group_zero_pending}, 8'h00);
        end
        @(posedge sys_clk);
        irq_one_src <= 8'h00;
        irq_zero_src <= 8'h00;
    endtask : t_irq

    task automatic crc_run(input logic cmd, input logic rz);
        @(posedge sys_clk);
        crc_ev <= '{start: 1'b1, from_command: cmd, busy: 1'b1, finish: 1'b0, remainder_zero: 1'b0};
        @(posedge sys_clk);
        crc_ev <= '{start: 1'b0, from_command: cmd, busy: 1'b1, finish: 1'b0, remainder_zero: 1'b0};
        #1;
        chk({7'h00, status.crc_result_zero}, 8'h00);
        if (cmd)
            chk({7'h00, status.crc_done}, 8'h00);
        @(posedge sys_clk);
        crc_ev <= '{start: 1'b0, from_command: cmd, busy: 1'b0, finish: 1'b1, remainder_zero: rz};
        @(posedge sys_clk);
        crc_ev <= '0;
        settle(1);
    endtask : crc_run

    task automatic t_crc();
        crc_run(1'b1, 1'b1);
        chk({6'h00, status.crc_result_zero, status.crc_done}, 8'h03);
        crc_run(1'b1, 1'b0);
        chk({6'h00, status.crc_result_zero, status.crc_done}, 8'h01);
        crc_run(1'b0, 1'b0);
        chk({7'h00, status.crc_done}, 8'h01);
    endtask : t_crc

    task automatic t_timer();
        @(posedge sys_clk);
        timer_gated_mode <= 1'b1;
        timer_enabled <= 1'b1;
        settle(2);
        chk({7'h00, status.timer_active}, 8'h01);
        @(posedge sys_clk);
        timer_gate <= 1'b1;
        settle(2);
        chk({7'h00, status.timer_active}, 8'h01);
        @(posedge sys_clk);
        timer_enabled <= 1'b0;
        settle(2);
        chk({7'h00, status.timer_active}, 8'h00);
    endtask : t_timer

    task automatic t_field();
        @(posedge sys_clk);
        field_detect_pin <= 1'b1;
        settle(4);
        chk({7'h00, status.field_present}, 8'h01);
        @(posedge sys_clk);
        field_detect_pin <= 1'b0;
        settle(4);
        chk({7'h00, status.field_present}, 8'h00);
    endtask : t_field

    task automatic t_fifo();
        int cnt[6] = '{60, 59, 4, 5, 64, 0};
        int thr[6] = '{4, 4, 4, 4, 0, 63};
        for (int i = 0; i < 6; i++)
        begin
            @(posedge sys_clk);
            fifo_fill_count <= 7'(cnt[i]);
            fifo_threshold <= 6'(thr[i]);
            settle(2);
            chk({7'h00, status.fifo_nearly_full}, 8'((64 - cnt[i]) <= thr[i]));
            chk({7'h00, status.fifo_nearly_empty}, 8'(cnt[i] <= thr[i]));
        end
    endtask : t_fifo

    task automatic end_sim();
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    initial
    begin
        #500000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        #1;
        chk(status, 8'h21);
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        settle(2);
        t_regs();
        t_irq();
        t_crc();
        t_timer();
        t_field();
        t_fifo();
        end_sim();
    end
endmodule : tb_transceiver_status_flags
